// ### rtc_calendar.sv
// Battery-backed calendar clock with scan-synchronous clock words
// Function
// - Time keeps counting on battery while main power is off.
// - Each scan end with main power on and no set-time request pending copies current time into the four clock words.
// - Words read month/year, hour/date, second/minute as four hex digits.
// - Fourth word holds century in upper byte, weekday in lower byte.
// - Hours run 0 to 23, dates 1 to 31.
// - Accepted years 1984 to 2163, months January to December.
// - Accepted minutes and seconds 0 to 59.
// - Weekday 0 is Sunday counting up to 6 Saturday.
// - Set-time block request loads the words into the clock at scan end.
// - Malformed time data is refused and the clock left unchanged.
// - Weekday is never checked; any value is stored silently.
// - Time is invalid after first use until a time is written.
// - A clock stop or error clears when a valid time is written.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Controller side
  input  wire logic        scan_end,
  input  wire logic        power_ok,
  input  wire logic        battery_fault,
  // Status
  output logic             time_valid,
  output logic             clock_error,
  output logic             irq
);

  typedef struct packed {
    logic [NFIELD-1:0][7:0] t;
    logic [7:0]             wk;
    logic [3:0][15:0]       word;
    logic                   wr_req;
    logic                   fb_req;
    logic                   valid;
    logic                   clk_err;
    logic [IRQ_BITS-1:0]    irq_st;
    logic [IRQ_BITS-1:0]    irq_msk;
    logic [31:0]            div;
    logic                   ack;
    logic [31:0]            rdata;
  } rtc_state_t;

  rtc_state_t s;
  rtc_state_t next_s;

  logic [NFIELD-1:0][7:0] step_nxt;
  logic [NFIELD-1:0]      step_wrap;
  logic [NFIELD-1:0][7:0] step_hi;
  logic [NFIELD-1:0][7:0] step_lo;
  logic                   tick;
  logic                   req_pend;
  logic                   words_ok;
  logic                   day_inc;
  logic                   bus_wr;
  logic                   ctrl_wr;
  logic [3:0][15:0]       time_words;

  // Field limits; the date limit tracks the month and leap years
  always_comb begin
    step_lo         = '0;
    step_hi         = '0;
    step_lo[F_SEC]  = BCD_ZERO;
    step_hi[F_SEC]  = BCD_MAX_SEC;
    step_lo[F_MIN]  = BCD_ZERO;
    step_hi[F_MIN]  = BCD_MAX_SEC;
    step_lo[F_HOUR] = BCD_ZERO;
    step_hi[F_HOUR] = BCD_MAX_HOUR;
    step_lo[F_DATE] = BCD_ONE;
    step_hi[F_DATE] = days_in(s.t[F_MON], s.t[F_YEAR], s.t[F_CENT]);
    step_lo[F_MON]  = BCD_ONE;
    step_hi[F_MON]  = BCD_MAX_MON;
    step_lo[F_YEAR] = BCD_ZERO;
    step_hi[F_YEAR] = BCD_MAX_YEAR;
    step_lo[F_CENT] = BCD_ZERO;
    step_hi[F_CENT] = BCD_MAX_CENT;
  end

  bcd_step_if stp[NFIELD] ();

  for (genvar i = 0; i < NFIELD; i++) begin : g_step
    assign stp[i].val    = s.t[i];
    assign stp[i].lo     = step_lo[i];
    assign stp[i].hi     = step_hi[i];
    assign step_nxt[i]   = stp[i].nxt;
    assign step_wrap[i]  = stp[i].wrap;
    bcd_step bcd_step_inst (
      .s (stp[i])
    );
  end

  // Words as the clock shows them, in BCD with first-named field high
  always_comb begin
    time_words[W_YM] = {s.t[F_MON], s.t[F_YEAR]};
    time_words[W_HD] = {s.t[F_HOUR], s.t[F_DATE]};
    time_words[W_SM] = {s.t[F_SEC], s.t[F_MIN]};
    time_words[W_CW] = {s.t[F_CENT], s.wk};
  end

  // Weekday is deliberately left out of the format check
  always_comb begin
    logic [7:0] mon;
    logic [7:0] yy;
    logic [7:0] cc;
    logic [7:0] dt;
    mon = s.word[W_YM][15:8];
    yy  = s.word[W_YM][7:0];
    cc  = s.word[W_CW][15:8];
    dt  = s.word[W_HD][7:0];
    words_ok = bcd_ok(mon) && bcd_ok(yy) && bcd_ok(cc) && bcd_ok(dt)
            && bcd_ok(s.word[W_HD][15:8]) && bcd_ok(s.word[W_SM][15:8])
            && bcd_ok(s.word[W_SM][7:0])
            && s.word[W_SM][15:8] <= BCD_MAX_SEC && s.word[W_SM][7:0] <= BCD_MAX_SEC
            && s.word[W_HD][15:8] <= BCD_MAX_HOUR
            && mon >= BCD_ONE && mon <= BCD_MAX_MON
            && dt >= BCD_ONE && dt <= days_in(mon, yy, cc)
            && ((cc == CENT_LOW && yy >= YEAR_FIRST) || cc == CENT_MID
                || (cc == CENT_HIGH && yy <= YEAR_LAST));
  end

  assign tick     = (s.div == 32'(TICK_LEN - 1));
  assign req_pend = s.wr_req || s.fb_req;
  assign bus_wr   = avs_write && s.ack && power_ok;
  assign ctrl_wr  = bus_wr && avs_address == ADDR_CONTROL && avs_byteenable[0];
  assign day_inc  = tick && !s.clk_err && step_wrap[F_SEC] && step_wrap[F_MIN]
                    && step_wrap[F_HOUR];

  always_comb begin
    logic carry;
    next_s = s;
    carry  = 1'b0;

    // One-second enable from the system clock
    next_s.div = tick ? '0 : s.div + 32'h0000_0001;

    // Counting runs on regardless of main power; a stopped clock holds
    if (tick && !s.clk_err) begin
      carry = 1'b1;
      for (int i = 0; i < NFIELD; i++) begin
        if (carry) begin
          next_s.t[i] = step_nxt[i];
          carry       = step_wrap[i];
        end
      end
    end
    if (day_inc) begin
      next_s.wk = (s.wk >= WEEK_LAST) ? RST_WEEK : s.wk + 8'h01;
    end

    // Bus handshake: every access waits exactly one cycle
    next_s.ack = (avs_read || avs_write) && !s.ack;
    if ((avs_read || avs_write) && !s.ack) begin
      case (avs_address)
        ADDR_YEAR_MONTH:    next_s.rdata = {16'h0000, s.word[W_YM]};
        ADDR_HOUR_DATE:     next_s.rdata = {16'h0000, s.word[W_HD]};
        ADDR_SECOND_MINUTE: next_s.rdata = {16'h0000, s.word[W_SM]};
        ADDR_CENTURY_WEEK:  next_s.rdata = {16'h0000, s.word[W_CW]};
        ADDR_CONTROL:       next_s.rdata = {30'h0000_0000, s.fb_req, s.wr_req};
        ADDR_STATUS:        next_s.rdata = {30'h0000_0000, s.clk_err, s.valid};
        ADDR_IRQ_STATUS:    next_s.rdata = {29'h0000_0000, s.irq_st};
        ADDR_IRQ_MASK:      next_s.rdata = {29'h0000_0000, s.irq_msk};
        default:            next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Clears first so that events landing in the same cycle win
    if (bus_wr && avs_byteenable[0]) begin
      if (avs_address == ADDR_IRQ_STATUS) begin
        next_s.irq_st = s.irq_st & ~avs_writedata[IRQ_BITS-1:0];
      end
      if (avs_address == ADDR_IRQ_MASK) begin
        next_s.irq_msk = avs_writedata[IRQ_BITS-1:0];
      end
    end

    // Scan end: load a requested time, otherwise refresh the words
    if (scan_end && power_ok) begin
      if (req_pend) begin
        if (words_ok) begin
          next_s.t[F_SEC]  = s.word[W_SM][15:8];
          next_s.t[F_MIN]  = s.word[W_SM][7:0];
          next_s.t[F_HOUR] = s.word[W_HD][15:8];
          next_s.t[F_DATE] = s.word[W_HD][7:0];
          next_s.t[F_MON]  = s.word[W_YM][15:8];
          next_s.t[F_YEAR] = s.word[W_YM][7:0];
          next_s.t[F_CENT] = s.word[W_CW][15:8];
          next_s.wk        = s.word[W_CW][7:0];
          next_s.valid     = 1'b1;
          next_s.clk_err   = 1'b0;
          next_s.div       = '0;
          next_s.irq_st[IRQ_ACCEPTED] = 1'b1;
        end else begin
          next_s.irq_st[IRQ_REFUSED] = 1'b1;
        end
        next_s.wr_req = 1'b0;
        next_s.fb_req = 1'b0;
      end else begin
        next_s.word = time_words;
      end
    end

    // Program writes win over the scan refresh and the request clear
    if (bus_wr) begin
      for (int w = 0; w < 4; w++) begin
        if (avs_address == 5'(w * 4)) begin
          if (avs_byteenable[0]) begin
            next_s.word[w][7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            next_s.word[w][15:8] = avs_writedata[15:8];
          end
        end
      end
    end
    if (ctrl_wr) begin
      next_s.wr_req = next_s.wr_req || avs_writedata[CTRL_WRITE_REQ];
      next_s.fb_req = next_s.fb_req || avs_writedata[CTRL_SET_BLOCK];
    end

    // A battery fault stops the count until a valid time is loaded
    if (battery_fault) begin
      next_s.clk_err           = 1'b1;
      next_s.irq_st[IRQ_FAULT] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s              <= '0;
      s.t[F_DATE]    <= RST_DATE;
      s.t[F_MON]     <= RST_MON;
      s.t[F_YEAR]    <= RST_YEAR;
      s.t[F_CENT]    <= RST_CENT;
      s.wk           <= RST_WEEK;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
  assign time_valid      = s.valid;
  assign clock_error     = s.clk_err;
  assign irq             = |(s.irq_st & s.irq_msk);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_scan_copy;
    scan_end && power_ok && !req_pend && !bus_wr |=> s.word == $past(time_words);
  endproperty
  a_scan_copy: assert property (p_scan_copy) else $error("words not refreshed");

  property p_hour_date;
    s.t[F_HOUR] <= BCD_MAX_HOUR && s.t[F_DATE] >= BCD_ONE && s.t[F_DATE] <= 8'h31;
  endproperty
  a_hour_date: assert property (p_hour_date) else $error("hour or date out of range");

  property p_min_sec;
    s.t[F_SEC] <= BCD_MAX_SEC && s.t[F_MIN] <= BCD_MAX_SEC;
  endproperty
  a_min_sec: assert property (p_min_sec) else $error("minute or second out of range");

  property p_week_wrap;
    day_inc && s.wk == WEEK_LAST && !(scan_end && power_ok && req_pend) |=> s.wk == RST_WEEK;
  endproperty
  a_week_wrap: assert property (p_week_wrap) else $error("weekday did not wrap");

  property p_load;
    scan_end && power_ok && req_pend && words_ok
      |=> s.t[F_SEC] == $past(s.word[W_SM][15:8]) && s.t[F_CENT] == $past(s.word[W_CW][15:8]);
  endproperty
  a_load: assert property (p_load) else $error("time not loaded");

  property p_refuse;
    scan_end && power_ok && req_pend && !words_ok && !tick |=> $stable(s.t);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad time changed clock");

  property p_week_kept;
    scan_end && power_ok && req_pend && words_ok |=> s.wk == $past(s.word[W_CW][7:0]);
  endproperty
  a_week_kept: assert property (p_week_kept) else $error("weekday altered");

  property p_error_clear;
    scan_end && power_ok && req_pend && words_ok && !battery_fault
      |=> !clock_error && time_valid;
  endproperty
  a_error_clear: assert property (p_error_clear) else $error("error not cleared");

  property p_req_clear;
    scan_end && power_ok && req_pend && !ctrl_wr
      |=> !s.wr_req && !s.fb_req && (s.irq_st[IRQ_ACCEPTED] || s.irq_st[IRQ_REFUSED]);
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request not consumed");

  property p_count;
    tick && !s.clk_err && !(scan_end && power_ok && req_pend) |=> s.t[F_SEC] != $past(s.t[F_SEC]);
  endproperty
  a_count: assert property (p_count) else $error("clock did not advance");

  property p_wait;
    avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");

  property p_refuse_flag;
    scan_end && power_ok && req_pend && !words_ok |=> s.irq_st[IRQ_REFUSED];
  endproperty
  a_refuse_flag: assert property (p_refuse_flag) else $error("refusal not flagged");

  // Set wins over a load in the same cycle, so the error survives it
  property p_fault_stop;
    battery_fault |=> clock_error && s.irq_st[IRQ_FAULT];
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("battery fault not latched");

  c_accept:  cover property (scan_end && power_ok && req_pend && words_ok);
  c_refuse:  cover property (scan_end && power_ok && req_pend && !words_ok);
  c_dayroll: cover property (day_inc);
  c_irq:     cover property ($rose(irq));

endmodule : rtc_calendar
`default_nettype wire

// ### rtc_pkg.sv
// Shared constants, layouts and helpers of the battery-backed calendar clock
package rtc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] ADDR_YEAR_MONTH     = 5'h00;
  localparam logic [4:0] ADDR_HOUR_DATE      = 5'h04;
  localparam logic [4:0] ADDR_SECOND_MINUTE  = 5'h08;
  localparam logic [4:0] ADDR_CENTURY_WEEK   = 5'h0C;
  localparam logic [4:0] ADDR_CONTROL        = 5'h10;
  localparam logic [4:0] ADDR_STATUS         = 5'h14;
  localparam logic [4:0] ADDR_IRQ_STATUS     = 5'h18;
  localparam logic [4:0] ADDR_IRQ_MASK       = 5'h1C;

  // Control bits
  localparam int CTRL_WRITE_REQ = 0;
  localparam int CTRL_SET_BLOCK = 1;
  // Status bits
  localparam int STAT_VALID     = 0;
  localparam int STAT_ERROR     = 1;
  // Interrupt bits
  localparam int IRQ_ACCEPTED   = 0;
  localparam int IRQ_REFUSED    = 1;
  localparam int IRQ_FAULT      = 2;
  localparam int IRQ_BITS       = 3;

  // Time field slots, counted in carry order
  localparam int F_SEC  = 0;
  localparam int F_MIN  = 1;
  localparam int F_HOUR = 2;
  localparam int F_DATE = 3;
  localparam int F_MON  = 4;
  localparam int F_YEAR = 5;
  localparam int F_CENT = 6;
  localparam int NFIELD = 7;

  // Clock word slots
  localparam int W_YM = 0;
  localparam int W_HD = 1;
  localparam int W_SM = 2;
  localparam int W_CW = 3;

  // BCD limits
  localparam logic [7:0] BCD_ZERO     = 8'h00;
  localparam logic [7:0] BCD_ONE      = 8'h01;
  localparam logic [7:0] BCD_MAX_SEC  = 8'h59;
  localparam logic [7:0] BCD_MAX_HOUR = 8'h23;
  localparam logic [7:0] BCD_MAX_MON  = 8'h12;
  localparam logic [7:0] BCD_MAX_YEAR = 8'h99;
  localparam logic [7:0] BCD_MAX_CENT = 8'h99;
  localparam logic [7:0] CENT_LOW     = 8'h19;
  localparam logic [7:0] CENT_MID     = 8'h20;
  localparam logic [7:0] CENT_HIGH    = 8'h21;
  localparam logic [7:0] YEAR_FIRST   = 8'h84;
  localparam logic [7:0] YEAR_LAST    = 8'h63;
  localparam logic [7:0] MON_FEB      = 8'h02;
  localparam logic [7:0] WEEK_LAST    = 8'h06;

  // Reset time: 1984-01-01 00:00:00, a Sunday
  localparam logic [7:0] RST_DATE     = 8'h01;
  localparam logic [7:0] RST_MON      = 8'h01;
  localparam logic [7:0] RST_YEAR     = 8'h84;
  localparam logic [7:0] RST_CENT     = 8'h19;
  localparam logic [7:0] RST_WEEK     = 8'h00;

  // Timing
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned TICK_S       = 1;
  localparam int unsigned TICK_CYCLES  = TICK_S * CLK_HZ;

  function automatic logic bcd_ok(input logic [7:0] b);
    return (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
  endfunction : bcd_ok

  // Leap when the BCD year is a multiple of four; year 00 only in century 20
  function automatic logic leap(input logic [7:0] yy, input logic [7:0] cc);
    logic m4;
    m4 = yy[4] ? (yy[3:0] == 4'h2 || yy[3:0] == 4'h6)
               : (yy[3:0] == 4'h0 || yy[3:0] == 4'h4 || yy[3:0] == 4'h8);
    return m4 && (yy != BCD_ZERO || cc == CENT_MID);
  endfunction : leap

  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yy,
                                         input logic [7:0] cc);
    logic [7:0] d;
    case (mon)
      8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
      MON_FEB:                    d = leap(yy, cc) ? 8'h29 : 8'h28;
      default:                    d = 8'h31;
    endcase
    return d;
  endfunction : days_in

endpackage : rtc_pkg

// ### bcd_step_if.sv
// Carrier between the calendar core and one BCD field stepper
`timescale 1ns/1ps
`default_nettype none
interface bcd_step_if;
  logic [7:0] val;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] nxt;
  logic       wrap;
  modport calc (input val, input lo, input hi, output nxt, output wrap);
  modport user (output val, output lo, output hi, input nxt, input wrap);
endinterface : bcd_step_if
`default_nettype wire

// ### bcd_step.sv
// One BCD field stepper: next value and wrap flag
`timescale 1ns/1ps
`default_nettype none
module bcd_step
  import rtc_pkg::*;
(
  // Field operands and result
  bcd_step_if.calc s
);
  always_comb begin
    s.wrap = (s.val >= s.hi);
    if (s.wrap) begin
      s.nxt = s.lo;
    end else if (s.val[3:0] == 4'h9) begin
      s.nxt = {s.val[7:4] + 4'h1, 4'h0};
    end else begin
      s.nxt = {s.val[7:4], s.val[3:0] + 4'h1};
    end
  end
endmodule : bcd_step
`default_nettype wire

// ### rtc_calendar_tb.sv
// Self-checking testbench of the battery-backed calendar clock
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_tb;
  import rtc_pkg::*;

  // Short second so that carries are reached quickly
  localparam int unsigned TL = 2000;

  logic        mclk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        scan_end;
  logic        power_ok;
  logic        battery_fault;
  logic        time_valid;
  logic        clock_error;
  logic        irq;
  int          miscompares;
  int          n_tests;
  logic [63:0] base;
  logic [63:0] bad [9];

  rtc_calendar #(.TICK_LEN(TL)) rtc_calendar_inst (
    .mclk            (mclk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .scan_end        (scan_end),
    .power_ok        (power_ok),
    .battery_fault   (battery_fault),
    .time_valid      (time_valid),
    .clock_error     (clock_error),
    .irq             (irq)
  );

  always #2.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge; data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask : rc

  task automatic scan();
    @(posedge mclk);
    scan_end <= 1'b1;
    @(posedge mclk);
    scan_end <= 1'b0;
  endtask : scan

  // Words packed as {year_month, hour_date, second_minute, century_weekday}
  task automatic load(input logic [63:0] w, input int b);
    wr(ADDR_YEAR_MONTH, {16'h0000, w[63:48]});
    wr(ADDR_HOUR_DATE, {16'h0000, w[47:32]});
    wr(ADDR_SECOND_MINUTE, {16'h0000, w[31:16]});
    wr(ADDR_CENTURY_WEEK, {16'h0000, w[15:0]});
    wr(ADDR_CONTROL, 32'h0000_0001 << b);
    scan();
  endtask : load

  task automatic words(input logic [63:0] w);
    rc(ADDR_YEAR_MONTH, {16'h0000, w[63:48]});
    rc(ADDR_HOUR_DATE, {16'h0000, w[47:32]});
    rc(ADDR_SECOND_MINUTE, {16'h0000, w[31:16]});
    rc(ADDR_CENTURY_WEEK, {16'h0000, w[15:0]});
  endtask : words

  task automatic t_reset();
    rc(ADDR_STATUS, 32'h0000_0000);
    rc(ADDR_CONTROL, 32'h0000_0000);
    rc(ADDR_IRQ_MASK, 32'h0000_0000);
    words(64'h0);
    chk({31'h0, time_valid}, 32'h0);
    scan();
    words(64'h0184_0001_0000_1900);
    $display("test reset done");
  endtask : t_reset

  task automatic t_load();
    load(base, CTRL_WRITE_REQ);
    rc(ADDR_IRQ_STATUS, 32'h0000_0001);
    rc(ADDR_CONTROL, 32'h0000_0000);
    rc(ADDR_STATUS, 32'h0000_0001);
    chk({31'h0, time_valid}, 32'h1);
    scan();
    words(base);
    wr(ADDR_IRQ_STATUS, 32'h0000_0007);
    // Changed in-range weekday: stored as given, no refusal
    load(64'h0599_1512_4142_2005, CTRL_SET_BLOCK);
    rc(ADDR_IRQ_STATUS, 32'h0000_0001);
    scan();
    rc(ADDR_CENTURY_WEEK, 32'h0000_2005);
    $display("test load done");
  endtask : t_load

  task automatic t_refuse();
    load(base, CTRL_WRITE_REQ);
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_IRQ_STATUS, 32'h0000_0007);
      load(bad[i], i % 2);
      rc(ADDR_IRQ_STATUS, 32'h0000_0002);
      rc(ADDR_CONTROL, 32'h0000_0000);
      scan();
      words(base);
    end
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_roll();
    // One second before 2000-01-01, weekday at its last value
    load(64'h1299_2331_5959_1906, CTRL_WRITE_REQ);
    repeat (TL + 20) @(posedge mclk);
    scan();
    words(64'h0100_0001_0000_2000);
    wr(ADDR_IRQ_STATUS, 32'h0000_0007);
    load(64'h1263_2331_5959_2106, CTRL_WRITE_REQ);
    rc(ADDR_IRQ_STATUS, 32'h0000_0001);
    $display("test rollover done");
  endtask : t_roll

  task automatic t_irq();
    wr(ADDR_IRQ_STATUS, 32'h0000_0007);
    rc(ADDR_IRQ_STATUS, 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    load(bad[0], CTRL_WRITE_REQ);
    // Pins are looked at mid-cycle, once the edge that updates them has passed
    @(negedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h0000_0002);
    rc(ADDR_IRQ_STATUS, 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_batt();
    wr(ADDR_IRQ_STATUS, 32'h0000_0007);
    @(posedge mclk);
    battery_fault <= 1'b1;
    @(posedge mclk);
    battery_fault <= 1'b0;
    rc(ADDR_STATUS, 32'h0000_0003);
    rc(ADDR_IRQ_STATUS, 32'h0000_0004);
    chk({31'h0, clock_error}, 32'h1);
    load(base, CTRL_SET_BLOCK);
    @(negedge mclk);
    chk({31'h0, clock_error}, 32'h0);
    rc(ADDR_STATUS, 32'h0000_0001);
    $display("test battery done");
  endtask : t_batt

  task automatic t_power();
    @(posedge mclk);
    power_ok <= 1'b0;
    wr(ADDR_YEAR_MONTH, 32'h0000_1234);
    scan();
    rc(ADDR_YEAR_MONTH, {16'h0000, base[63:48]});
    // Time keeps running without main power
    repeat (TL) @(posedge mclk);
    power_ok <= 1'b1;
    scan();
    rc(ADDR_SECOND_MINUTE, 32'h0000_4242);
    $display("test power done");
  endtask : t_power

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial begin
    repeat (12 * TL) @(posedge mclk);
    miscompares++;
    complete_run();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    scan_end = 1'b0;
    power_ok = 1'b1;
    battery_fault = 1'b0;
    miscompares = 0;
    n_tests = 0;
    base = 64'h0599_1512_4142_2001;
    bad = '{64'h0599_1512_6042_2001, 64'h0599_1512_4160_2001, 64'h0599_2412_4142_2001,
            64'h0599_1532_4142_2001, 64'h1399_1512_4142_2001, 64'h0099_1512_4142_2001,
            64'h0583_1512_4142_1901, 64'h0564_1512_4142_2101, 64'h0599_1A12_4142_2001};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_load();
    t_refuse();
    t_roll();
    t_irq();
    t_batt();
    t_power();
    complete_run();
  end
endmodule : rtc_calendar_tb
`default_nettype wire
